// [design/swt_pkg.sv]
// package for the service window timer with clock monitor
// shared by the top module, the clock monitor and the release delay counter
package swt_pkg;

    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFF_SVC = 8'h00; // service register
    localparam logic [7:0] OFF_CTRL = 8'h04; // low-power mode and oscillator bits
    localparam logic [7:0] OFF_STAT = 8'h08; // live state, pending flag (write 1 clears)
    localparam logic [7:0] OFF_COUNT = 8'h0c; // window count in instruction cycles

    // service register field layout
    localparam int SVC_WIN_MSB = 7;
    localparam int SVC_WIN_LSB = 6;
    localparam int SVC_KEY_MSB = 5;
    localparam int SVC_KEY_LSB = 1;
    localparam int SVC_CM_BIT = 0;
    localparam logic [4:0] SVC_KEY = 5'h0c; // fixed key pattern 01100

    // values taken when leaving reset
    localparam logic [1:0] WIN_RESET = 2'h3; // widest window
    localparam logic CM_EN_RESET = 1'b1; // clock monitor enabled

    // status register bit positions
    localparam int ST_WD_DRIVE = 0;
    localparam int ST_CM_FAULT = 1;
    localparam int ST_LOCKED = 2;
    localparam int ST_IDLE_PEND = 3;
    localparam int ST_PIN_LEVEL = 4;

    // window limits in instruction cycles
    localparam int CNT_W = 17; // wide enough for 65536
    localparam logic [CNT_W-1:0] LOWER_LIMIT = 17'h00800; // 2048
    localparam logic [CNT_W-1:0] UPPER_BASE = 17'h02000; // 8k, doubled per code step

    // instruction cycle derivation from the oscillator pin
    localparam logic [3:0] OSC_PER_TC = 4'ha; // oscillator edges per instruction cycle
    localparam int unsigned CLK_PERIOD_NS = 50; // 20 MHz system clock
    localparam int unsigned MON_LIMIT_NS = 1000000; // longest tolerated cycle, 1 ms
    localparam int unsigned MON_LIMIT_CLKS_DEF = MON_LIMIT_NS / CLK_PERIOD_NS;
    localparam int MON_W = 24;

    // release delay after the pin is seen low, in instruction cycles (16 to 32)
    localparam logic [5:0] RELEASE_TICKS = 6'h14;

    // idle timer: pending flag set as bit 12 toggles
    localparam int IDLE_W = 16;
    localparam logic [11:0] IDLE_WRAP = 12'hfff;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // low-power mode and oscillator option bits held in the control register
    typedef struct packed {
        logic clock_delay_bit; // bit 3
        logic rc_osc; // bit 2: 1 = single-pin R/C, 0 = crystal
        logic idle; // bit 1
        logic halt; // bit 0
    } ctrl_t;

    // service-window checker states
    typedef enum logic [1:0] {
        WD_ARMED,
        WD_DRIVE,
        WD_HOLD,
        WD_WAIT_HIGH
    } wd_state_t;

endpackage : swt_pkg

// [design/release_delay.sv]
// release delay counter for the alarm pin
// counts instruction-cycle ticks after clear falls; idle at full count after reset
`timescale 1ns/1ps
module release_delay import swt_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic tick_i,
    output logic done_o
);

    logic [5:0] cnt_q; // ticks counted since the clear
    logic [5:0] cnt_d;

    // restart on clear, otherwise step on each tick until full
    assign cnt_d = clear_i ? 6'h00 :
                   (tick_i && cnt_q != RELEASE_TICKS) ? cnt_q + 6'h01 : cnt_q;
    assign done_o = (cnt_q == RELEASE_TICKS);

    // counter register, full after reset so nothing is driven
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= RELEASE_TICKS;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : release_delay

// [design/tc_clock_monitor.sv]
// instruction-cycle tick generator and clock frequency monitor
// expects the oscillator level already synchronous to the system clock
`timescale 1ns/1ps
module tc_clock_monitor import swt_pkg::*; #(
    parameter int unsigned LIMIT_CLKS = MON_LIMIT_CLKS_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_i,
    output logic tick_o,
    output logic fault_o
);

    logic osc_q; // previous oscillator level
    logic [3:0] div_q; // oscillator edges within this cycle
    logic [MON_W-1:0] gap_q; // system clocks since the last tick
    logic tick_q;
    logic fault_q;
    logic rise;
    logic tick_d;
    logic gap_full;

    assign rise = osc_i & ~osc_q;
    assign tick_d = rise && (div_q == OSC_PER_TC - 4'h1);
    assign gap_full = (gap_q == LIMIT_CLKS[MON_W-1:0]);
    assign tick_o = tick_q;
    assign fault_o = fault_q;

    // divide oscillator edges into instruction cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_q <= 1'b0;
            div_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            osc_q <= osc_i;
            tick_q <= tick_d;
            if (tick_d) begin
                div_q <= 4'h0;
            end else if (rise) begin
                div_q <= div_q + 4'h1;
            end
        end
    end

    // a cycle longer than the limit is a fault; the next tick ends it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_q <= '0;
            fault_q <= 1'b0; // inhibited while in reset
        end else begin
            if (tick_q) begin
                gap_q <= '0;
                fault_q <= 1'b0; // frequency back in range
            end else if (!gap_full) begin
                gap_q <= gap_q + MON_W'(1);
            end else begin
                fault_q <= 1'b1; // slow or dead oscillator
            end
        end
    end

endmodule : tc_clock_monitor

// [design/service_window_timer_clock_monitor.sv]
// service window timer with clock monitor, AXI4-Lite register slave
// assumes an external pull-up on the alarm pin and a synchronous pin sense
// Operation
// - service register: window, key, monitor select fields
// - valid write needs key 01100
// - lower limit fixed at 2048 cycles
// - window code picks 8k, 16k, 32k, 64k
// - monitor select bit disables or enables checking
// - reset inhibits checker and monitor
// - leave reset with maximum window, monitor on
// - first service anywhere in first window
// - first keyed write locks settings until reset
// - later writes compare bits 7 to 1; the code also compares bit 0, the monitor select bit
// - no service before upper limit is error
// - early service before lower limit is error
// - drive low until sensed low, then delay
// - window restarts when pin returns high
// - service during active alarm is ignored
// - monitor drives pin, releases after delay
// - accept 10 kHz, reject below 10 Hz
// - key field reads as zero
// - checker off in HALT, IDLE; monitor stays
// - R/C without clock delay resumes count
// - crystal or clock delay restarts after HALT
// - IDLE exit gives hardware service
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module service_window_timer_clock_monitor import swt_pkg::*; #(
    parameter int unsigned MON_LIMIT_CLKS = MON_LIMIT_CLKS_DEF
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic CLOCK_INPUT_PIN_I,
    input wire logic ALARM_OUT_PIN_I,
    output logic ALARM_OUT_PIN_O,
    output logic ALARM_OUT_PIN_OE_N_O
);

    // decode helpers, shared by the write and read paths
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[7:4] == 4'h0) && (a[1:0] == 2'h0);
    endfunction : addr_ok

    // upper window limit from the window code, 8k shifted by the code
    function automatic logic [CNT_W-1:0] upper_lim(input logic [1:0] code);
        upper_lim = UPPER_BASE << code;
    endfunction : upper_lim

    // bus slave state
    logic aw_have_q; // write address held
    logic w_have_q; // write data held
    logic [7:0] aw_addr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // block state
    ctrl_t ctrl_q; // low-power modes and oscillator option
    logic [1:0] win_q; // stored window code
    logic cm_en_q; // stored monitor select
    logic locked_q; // first keyed write done
    logic [CNT_W-1:0] count_q; // instruction cycles since restart
    wd_state_t state_q; // checker state
    logic halt_prev_q; // halt bit one cycle ago
    logic idle_prev_q; // idle bit one cycle ago
    logic [IDLE_W-1:0] idle_cnt_q; // free running idle timer
    logic pend_q; // idle timer pending flag
    logic pin_lvl_q; // alarm pin output level
    logic oe_n_q; // alarm pin enable, low drives

    // decoded wires
    logic tick; // one instruction cycle elapsed
    logic cm_fault; // oscillator too slow
    logic wd_done; // checker release delay over
    logic cm_done; // monitor release delay over
    logic wr_fire;
    logic wr_ok;
    logic svc_wr;
    logic ctrl_wr;
    logic stat_wr;
    logic [7:0] svc_byte;
    logic key_ok;
    logic cfg_ok;
    logic inhibit;
    logic armed;
    logic svc_take;
    logic svc_good;
    logic svc_bad;
    logic timeout;
    logic halt_exit;
    logic idle_exit;
    logic restart;
    logic wd_drive;
    logic cm_drive;
    logic pend_set;
    logic pend_clr;
    logic rd_ok;
    logic [31:0] rd_word;

    // instruction cycle source and clock monitor; halt stops the clock
    tc_clock_monitor #(
        .LIMIT_CLKS(MON_LIMIT_CLKS)
    ) u_mon (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .osc_i(CLOCK_INPUT_PIN_I & ~ctrl_q.halt),
        .tick_o(tick),
        .fault_o(cm_fault)
    );

    // checker release delay, held cleared until the pin is seen low
    release_delay u_wd_rel (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .clear_i(state_q == WD_DRIVE),
        .tick_i(tick),
        .done_o(wd_done)
    );

    // monitor release delay, held cleared while the fault lasts
    release_delay u_cm_rel (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .clear_i(cm_fault),
        .tick_i(tick),
        .done_o(cm_done)
    );

    // write decode: one write at a time, once address and data are both held
    assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    assign wr_ok = addr_ok(aw_addr_q);
    assign svc_wr = wr_fire && wr_ok && aw_addr_q == OFF_SVC && wstrb_q[0];
    assign ctrl_wr = wr_fire && wr_ok && aw_addr_q == OFF_CTRL && wstrb_q[0];
    assign stat_wr = wr_fire && wr_ok && aw_addr_q == OFF_STAT && wstrb_q[0];
    assign svc_byte = wdata_q[7:0];

    // service write checks
    assign key_ok = (svc_byte[SVC_KEY_MSB:SVC_KEY_LSB] == SVC_KEY);
    assign cfg_ok = key_ok && svc_byte[SVC_WIN_MSB:SVC_WIN_LSB] == win_q
                    && svc_byte[SVC_CM_BIT] == cm_en_q;
    assign inhibit = ctrl_q.halt | ctrl_q.idle;
    assign armed = (state_q == WD_ARMED);
    assign svc_take = svc_wr & armed & ~inhibit; // ignored while alarm active
    // first service only needs the key and may come early
    assign svc_good = locked_q ? (cfg_ok && count_q >= LOWER_LIMIT) : key_ok;
    assign svc_bad = svc_take & ~svc_good;
    assign timeout = armed && !inhibit && count_q >= upper_lim(win_q);

    // low-power exits
    assign halt_exit = halt_prev_q & ~ctrl_q.halt;
    assign idle_exit = idle_prev_q & ~ctrl_q.idle;

    // window restart sources
    assign restart = (svc_take & svc_good)
                     | idle_exit // hardware service
                     | (halt_exit & ~(ctrl_q.rc_osc & ~ctrl_q.clock_delay_bit))
                     | (state_q == WD_WAIT_HIGH && ALARM_OUT_PIN_I);

    // pin drive requests
    assign wd_drive = (state_q == WD_DRIVE) || (state_q == WD_HOLD);
    assign cm_drive = cm_en_q & (cm_fault | ~cm_done);

    // idle timer pending flag, set wins over a clear in the same cycle
    assign pend_set = tick && idle_cnt_q[11:0] == IDLE_WRAP;
    assign pend_clr = stat_wr && wdata_q[ST_IDLE_PEND];

    // read data selection
    assign rd_ok = addr_ok(S_AXI_ARADDR_I);
    assign rd_word = (S_AXI_ARADDR_I == OFF_SVC) ? {24'h0, win_q, 5'h00, cm_en_q} :
                     (S_AXI_ARADDR_I == OFF_CTRL) ? {28'h0, ctrl_q} :
                     (S_AXI_ARADDR_I == OFF_STAT) ? {27'h0, ALARM_OUT_PIN_I, pend_q,
                                                     locked_q, cm_fault, wd_drive} :
                     {15'h0, count_q};

    // write address and data channels, taken in either order
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_addr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            // ready is a one-cycle pulse offered to a waiting valid
            awready_q <= S_AXI_AWVALID_I & ~awready_q & ~aw_have_q & ~bvalid_q;
            wready_q <= S_AXI_WVALID_I & ~wready_q & ~w_have_q & ~bvalid_q;
            if (S_AXI_AWVALID_I && awready_q) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_I;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (S_AXI_WVALID_I && wready_q) begin
                w_have_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // write response follows both halves
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR; // unmapped address
        end else if (S_AXI_BREADY_I) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= S_AXI_ARVALID_I & ~arready_q & ~rvalid_q;
            if (S_AXI_ARVALID_I && arready_q) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_ok ? rd_word : 32'h0;
                rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY_I) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // control register and mode edge history
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ctrl_q <= '0;
            halt_prev_q <= 1'b0;
            idle_prev_q <= 1'b0;
        end else begin
            halt_prev_q <= ctrl_q.halt;
            idle_prev_q <= ctrl_q.idle;
            if (ctrl_wr) begin
                ctrl_q <= ctrl_t'(wdata_q[3:0]);
            end
        end
    end

    // stored settings, loaded only by the first keyed write
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            win_q <= WIN_RESET;
            cm_en_q <= CM_EN_RESET;
            locked_q <= 1'b0;
        end else if (svc_take && !locked_q && key_ok) begin
            win_q <= svc_byte[SVC_WIN_MSB:SVC_WIN_LSB];
            cm_en_q <= svc_byte[SVC_CM_BIT];
            locked_q <= 1'b1;
        end
    end

    // window count in instruction cycles, frozen while inhibited
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            count_q <= '0;
        end else if (restart) begin
            count_q <= '0;
        end else if (armed && !inhibit && tick && !timeout) begin
            count_q <= count_q + CNT_W'(1); // resumes after halt when kept
        end
    end

    // checker state: error, drive until sensed low, hold, wait for high
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            state_q <= WD_ARMED;
        end else begin
            case (state_q)
                WD_ARMED: begin
                    if (svc_bad || timeout) begin
                        state_q <= WD_DRIVE;
                    end
                end
                WD_DRIVE: begin
                    if (!ALARM_OUT_PIN_I) begin
                        state_q <= WD_HOLD;
                    end
                end
                WD_HOLD: begin
                    if (wd_done) begin
                        state_q <= WD_WAIT_HIGH;
                    end
                end
                WD_WAIT_HIGH: begin
                    if (ALARM_OUT_PIN_I) begin
                        state_q <= WD_ARMED;
                    end
                end
                default: begin
                    state_q <= WD_ARMED;
                end
            endcase
        end
    end

    // idle timer and its pending flag
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            idle_cnt_q <= '0;
            pend_q <= 1'b0;
        end else begin
            if (tick) begin
                idle_cnt_q <= idle_cnt_q + IDLE_W'(1);
            end
            if (pend_set) begin
                pend_q <= 1'b1;
            end else if (pend_clr) begin
                pend_q <= 1'b0;
            end
        end
    end

    // open-drain alarm pin: level always low, enable low while driving
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            pin_lvl_q <= 1'b0;
            oe_n_q <= 1'b1; // released during reset
        end else begin
            pin_lvl_q <= 1'b0;
            oe_n_q <= ~(wd_drive | cm_drive);
        end
    end

    // outputs straight from flip-flops
    assign S_AXI_AWREADY_O = awready_q;
    assign S_AXI_WREADY_O = wready_q;
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign S_AXI_ARREADY_O = arready_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RDATA_O = rdata_q;
    assign S_AXI_RRESP_O = rresp_q;
    assign ALARM_OUT_PIN_O = pin_lvl_q;
    assign ALARM_OUT_PIN_OE_N_O = oe_n_q;

endmodule : service_window_timer_clock_monitor

// [sim/swt_monitor.sv]
// assertion checker for the service window timer top module
// bound to the top module; sees its ports only
`timescale 1ns/1ps
module swt_monitor import swt_pkg::*; (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic CLOCK_INPUT_PIN_I,
    input wire logic ALARM_OUT_PIN_I,
    input wire logic ALARM_OUT_PIN_O,
    input wire logic ALARM_OUT_PIN_OE_N_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [7:0] aw_q; // address of the last write taken
    logic [7:0] ar_q; // address of the last read taken
    logic ck_q; // oscillator level one clock ago
    logic [9:0] edges_q; // oscillator edges while the wire is held low
    wire aw_bad = (aw_q > OFF_COUNT) || (aw_q[1:0] != 2'h0); // unmapped write
    wire ar_bad = (ar_q > OFF_COUNT) || (ar_q[1:0] != 2'h0); // unmapped read
    // capture addresses, count edges of each low stretch
    always_ff @(posedge CLK_I) begin
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) aw_q <= S_AXI_AWADDR_I;
        if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) ar_q <= S_AXI_ARADDR_I;
        ck_q <= CLOCK_INPUT_PIN_I;
        if (SYS_RST_I || ALARM_OUT_PIN_OE_N_O) edges_q <= 10'h000;
        else if (!ALARM_OUT_PIN_I && CLOCK_INPUT_PIN_I && !ck_q) edges_q <= edges_q + 10'h001;
    end
    a_reset_quiet: assert property (disable iff (1'b0) SYS_RST_I |=>
        ALARM_OUT_PIN_OE_N_O && !S_AXI_BVALID_O && !S_AXI_RVALID_O) else $error("busy in reset");
    a_open_drain: assert property (!ALARM_OUT_PIN_O) else $error("pin driven high");
    a_hold_till_low: assert property (!ALARM_OUT_PIN_OE_N_O && ALARM_OUT_PIN_I
        |=> !ALARM_OUT_PIN_OE_N_O) else $error("released before sensed low");
    a_release_max: assert property (edges_q <= 10'd330) else $error("held too long");
    a_release_min: assert property ($rose(ALARM_OUT_PIN_OE_N_O) |->
        edges_q >= 10'd150) else $error("released too soon");
    a_key_zero: assert property (S_AXI_RVALID_O && ar_q == OFF_SVC |->
        S_AXI_RDATA_O[5:1] == 5'h00) else $error("key visible");
    a_write_resp: assert property (S_AXI_BVALID_O |->
        S_AXI_BRESP_O == (aw_bad ? RESP_SLVERR : RESP_OKAY)) else $error("bad write resp");
    a_read_resp: assert property (S_AXI_RVALID_O && ar_bad |->
        S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0) else $error("bad read resp");
    a_bvalid_after: assert property (S_AXI_AWREADY_O && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O)
        else $error("no write answer");
    c_alarm: cover property ($fell(ALARM_OUT_PIN_OE_N_O));
    c_unmapped: cover property (S_AXI_RVALID_O && ar_bad);
    c_release: cover property ($rose(ALARM_OUT_PIN_OE_N_O));
endmodule : swt_monitor
bind service_window_timer_clock_monitor swt_monitor swt_monitor_inst (.CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I), .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
    .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .CLOCK_INPUT_PIN_I(CLOCK_INPUT_PIN_I), .ALARM_OUT_PIN_I(ALARM_OUT_PIN_I),
    .ALARM_OUT_PIN_O(ALARM_OUT_PIN_O), .ALARM_OUT_PIN_OE_N_O(ALARM_OUT_PIN_OE_N_O));

// [sim/alarm_pullup.sv]
// pull-up model of the external reset line on the alarm wire
// the wire falls a few clocks after the pull starts and rises at once on release
`timescale 1ns/1ps
module alarm_pullup #(
    parameter int FALL = 4
) (
    input wire logic clk_i,
    input wire logic oe_n_i,
    output logic level_o
);
    int low_q = 0; // clocks the device has pulled the wire
    // slow falling edge through the line capacitance
    always_ff @(posedge clk_i) begin
        low_q <= oe_n_i ? 0 : low_q + 1;
    end
    assign level_o = oe_n_i || (low_q < FALL);
endmodule : alarm_pullup

// [sim/tb.sv]
// self-checking bench for the service window timer
// drives AXI4-Lite and the oscillator pin; pull-up model on the alarm wire
`timescale 1ns/1ps
module tb import swt_pkg::*;;
    logic clk = 1'b0; // 20 MHz system clock
    logic rst = 1'b1; // synchronous reset
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0; // write word
    logic osc = 1'b0; // oscillator pin, one instruction cycle per 20 clocks
    logic awready, wready, bvalid, arready, rvalid, pin_o, oe_n, pin;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int err_total = 0, num_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    always @(posedge clk) osc <= ~osc;
    service_window_timer_clock_monitor #(.MON_LIMIT_CLKS(200))
        service_window_timer_clock_monitor_inst (.CLK_I(clk), .SYS_RST_I(rst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .CLOCK_INPUT_PIN_I(osc),
        .ALARM_OUT_PIN_I(pin), .ALARM_OUT_PIN_O(pin_o), .ALARM_OUT_PIN_OE_N_O(oe_n));
    alarm_pullup alarm_pullup_inst (.clk_i(clk), .oe_n_i(oe_n), .level_o(pin));
    // compare and count
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // print counts and verdict, then stop
    task summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // one AXI4-Lite write; response lands in rs
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
            if (wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    // one AXI4-Lite read; data in rd, response in rs
    task rdt(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rdt
    // wait for the alarm enable to reach a level
    task wait_oe(input logic v);
        while (oe_n !== v) @(posedge clk);
    endtask : wait_oe
    // cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdt(OFF_SVC); check("svc reset", rd, 32'hc1);
        rdt(OFF_STAT); check("stat reset", rd, 32'h10);
        rdt(8'h10); check("unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(OFF_SVC, 32'h19); check("first svc", {30'h0, rs}, 32'h0);
        rdt(OFF_STAT); check("locked", rd, 32'h14);
        rdt(OFF_SVC); check("svc loaded", rd, 32'h01);
        wr(OFF_SVC, 32'h19); // early second service
        wait_oe(1'b0);
        rdt(OFF_STAT); check("early drive", rd[0], 32'h1);
        wr(OFF_SVC, 32'hd9); // ignored while the alarm is active
        wait_oe(1'b1);
        rdt(OFF_COUNT); check("restart", rd < 32'h4, 32'h1);
        rdt(OFF_SVC); check("svc kept", rd, 32'h01);
        repeat (2100 * 20) @(posedge clk);
        wr(OFF_SVC, 32'h19);
        repeat (40) @(posedge clk);
        check("late svc", oe_n, 32'h1);
        rdt(OFF_COUNT); check("svc restart", rd < 32'h4, 32'h1);
        repeat (2100 * 20) @(posedge clk);
        wr(OFF_SVC, 32'h18); // monitor bit differs from the stored one
        repeat (3) @(posedge clk);
        check("mismatch", oe_n, 32'h0);
        wait_oe(1'b1);
        rdt(OFF_SVC); check("svc fixed", rd, 32'h01);
        repeat (4000) @(posedge clk);
        wr(OFF_CTRL, 32'h1); // halt stops the instruction clock
        wait_oe(1'b0);
        wr(OFF_CTRL, 32'h0);
        rdt(OFF_STAT); check("clock fault", rd[1:0], 32'h2);
        wait_oe(1'b1);
        rdt(OFF_COUNT); check("halt restart", rd < 32'h20, 32'h1);
        repeat (4000) @(posedge clk);
        wr(OFF_CTRL, 32'h2);
        rdt(OFF_CTRL); check("ctrl idle", rd, 32'h2);
        wr(OFF_CTRL, 32'h0);
        rdt(OFF_COUNT); check("idle restart", rd < 32'h4, 32'h1);
        check("no alarm", oe_n, 32'h1);
        summarize();
    end
endmodule : tb
